//--- design/lclr_level_slot.sv
// one loop level register: staging copy plus active copy
`timescale 1ns/1ps
module lclr_level_slot
	import lclr_pkg::*;
(
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       srst,
	// staging write and transfer
	input  wire logic       stage_we,
	input  wire logic [2:0] stage_wdata,
	input  wire logic       xfer,
	// copies
	output logic      [2:0] stage_q,
	output logic      [2:0] active_q
);

	always_ff @(posedge core_clk)
	begin
		if (srst)
			stage_q <= LCLR_LEVEL_RST;
		else if (stage_we)
			stage_q <= stage_wdata;
	end

	// a staging write in the transfer cycle is not taken into the active copy
	always_ff @(posedge core_clk)
	begin
		if (srst)
			active_q <= LCLR_LEVEL_RST;
		else if (xfer)
			active_q <= stage_q;
	end

endmodule : lclr_level_slot

//--- design/lclr_pkg.sv
// package: register map, field layout and codes for the loop level registers
package lclr_pkg;

	localparam int          LCLR_ADDR_W        = 16;
	localparam int          LCLR_DATA_W        = 8;
	localparam int          LCLR_LOOPS         = 4;
	localparam int          LCLR_PINS          = 2;

	// register offsets
	localparam logic [15:0] LCLR_XFER_ADDR     = 16'h000F;
	localparam logic [15:0] LCLR_KEY_ADDR      = 16'h0FFF;
	localparam logic [15:0] LCLR_LOOP0_ADDR    = 16'h1488;
	localparam logic [15:0] LCLR_LOOP1_ADDR    = 16'h1588;
	localparam logic [15:0] LCLR_LOOP2_ADDR    = 16'h1688;
	localparam logic [15:0] LCLR_LOOP3_ADDR    = 16'h1788;
	localparam logic [15:0] LCLR_PIN0_ADDR     = 16'h0200;
	localparam logic [15:0] LCLR_PIN1_ADDR     = 16'h0201;

	// field layout of a loop level register
	localparam int          LCLR_OVR_BIT       = 0;
	localparam int          LCLR_LVL_LSB       = 1;
	localparam int          LCLR_LVL_MSB       = 2;

	// magic values
	localparam logic [7:0]  LCLR_XFER_GO       = 8'h01;
	localparam logic [7:0]  LCLR_KEY_UNLOCK    = 8'hF9;
	localparam logic [7:0]  LCLR_PIN_LOW       = 8'h80;
	localparam logic [7:0]  LCLR_PIN_HIGH      = 8'h81;
	localparam int          LCLR_PIN_DIR_BIT   = 7;

	// reset values
	localparam logic [2:0]  LCLR_LEVEL_RST     = 3'h0;
	localparam logic [7:0]  LCLR_KEY_RST       = 8'h00;
	localparam logic [7:0]  LCLR_PIN_RST       = 8'h00;

	// pin function decode
	typedef enum logic [1:0] {
		LCLR_PIN_INPUT = 2'b00,
		LCLR_PIN_DRV0  = 2'b01,
		LCLR_PIN_DRV1  = 2'b10,
		LCLR_PIN_OTHER = 2'b11
	} lclr_pin_mode_t;

endpackage : lclr_pkg

//--- design/lclr_regs.sv
// loop calibration level register bank with two static multifunction pins
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
module lclr_regs
	import lclr_pkg::*;
(
	// clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   srst,
	// register port
	input  wire logic [LCLR_ADDR_W-1:0] reg_addr,
	input  wire logic [LCLR_DATA_W-1:0] reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output logic      [LCLR_DATA_W-1:0] reg_rdata,
	// active calibration settings, one lane per loop
	output logic      [7:0]             loop_level_select,
	output logic      [3:0]             loop_override_enable,
	output logic                        level_locked,
	// multifunction pins
	output logic      [1:0]             mfp_out,
	output logic      [1:0]             mfp_oe
);

	logic [LCLR_DATA_W-1:0] key_q;
	logic [LCLR_DATA_W-1:0] pin_fn_q [LCLR_PINS];
	logic                   unlocked;
	logic                   xfer;
	logic [3:0]             loop_hit;
	logic [2:0]             stage_q  [LCLR_LOOPS];
	logic [2:0]             active_q [LCLR_LOOPS];
	logic [LCLR_DATA_W-1:0] rdata_d;
	lclr_pin_mode_t         pin_mode [LCLR_PINS];

	assign unlocked = (key_q == LCLR_KEY_UNLOCK);
	// the strobe register is self clearing: only the write cycle matters
	assign xfer = reg_wr && (reg_addr == LCLR_XFER_ADDR)
		&& (reg_wdata == LCLR_XFER_GO);

	assign loop_hit[0] = (reg_addr == LCLR_LOOP0_ADDR);
	assign loop_hit[1] = (reg_addr == LCLR_LOOP1_ADDR);
	assign loop_hit[2] = (reg_addr == LCLR_LOOP2_ADDR);
	assign loop_hit[3] = (reg_addr == LCLR_LOOP3_ADDR);

	always_ff @(posedge core_clk)
	begin
		if (srst)
			key_q <= LCLR_KEY_RST;
		else if (reg_wr && reg_addr == LCLR_KEY_ADDR)
			key_q <= reg_wdata;
	end

	genvar g;
	generate
		for (g = 0; g < LCLR_LOOPS; g++)
		begin : g_loop
			// locked writes are dropped so a stray access cannot retune a loop
			lclr_level_slot u_slot (
				.core_clk    (core_clk),
				.srst        (srst),
				.stage_we    (reg_wr && loop_hit[g] && unlocked),
				.stage_wdata (reg_wdata[LCLR_LVL_MSB:LCLR_OVR_BIT]),
				.xfer        (xfer),
				.stage_q     (stage_q[g]),
				.active_q    (active_q[g])
			);
		end
		for (g = 0; g < LCLR_PINS; g++)
		begin : g_pin
			always_ff @(posedge core_clk)
			begin
				if (srst)
					pin_fn_q[g] <= LCLR_PIN_RST;
				else if (reg_wr && reg_addr == (LCLR_PIN0_ADDR + 16'(g)))
					pin_fn_q[g] <= reg_wdata;
			end

			always_comb
			begin
				if (!pin_fn_q[g][LCLR_PIN_DIR_BIT])
					pin_mode[g] = LCLR_PIN_INPUT;
				else if (pin_fn_q[g] == LCLR_PIN_LOW)
					pin_mode[g] = LCLR_PIN_DRV0;
				else if (pin_fn_q[g] == LCLR_PIN_HIGH)
					pin_mode[g] = LCLR_PIN_DRV1;
				else
					pin_mode[g] = LCLR_PIN_OTHER;
			end

			// other output codes are outside this block and drive low
			always_ff @(posedge core_clk)
			begin
				if (srst)
				begin
					mfp_out[g] <= 1'b0;
					mfp_oe[g]  <= 1'b0;
				end
				else
				begin
					unique case (pin_mode[g])
						LCLR_PIN_INPUT:
						begin
							mfp_out[g] <= 1'b0;
							mfp_oe[g]  <= 1'b0;
						end
						LCLR_PIN_DRV0:
						begin
							mfp_out[g] <= 1'b0;
							mfp_oe[g]  <= 1'b1;
						end
						LCLR_PIN_DRV1:
						begin
							mfp_out[g] <= 1'b1;
							mfp_oe[g]  <= 1'b1;
						end
						LCLR_PIN_OTHER:
						begin
							mfp_out[g] <= 1'b0;
							mfp_oe[g]  <= 1'b1;
						end
					endcase
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			loop_level_select    <= 8'h00;
			loop_override_enable <= 4'h0;
			level_locked         <= 1'b1;
		end
		else
		begin
			for (int i = 0; i < LCLR_LOOPS; i++)
			begin
				loop_level_select[2*i +: 2] <=
					active_q[i][LCLR_LVL_MSB:LCLR_LVL_LSB];
				loop_override_enable[i] <= active_q[i][LCLR_OVR_BIT];
			end
			level_locked <= !unlocked;
		end
	end

	// reads return the staging copy; reserved bits read zero
	always_comb
	begin
		rdata_d = 8'h00;
		for (int i = 0; i < LCLR_LOOPS; i++)
		begin
			if (loop_hit[i])
				rdata_d = {5'h00, stage_q[i]};
		end
		if (reg_addr == LCLR_KEY_ADDR)
			rdata_d = key_q;
		if (reg_addr == LCLR_PIN0_ADDR)
			rdata_d = pin_fn_q[0];
		if (reg_addr == LCLR_PIN1_ADDR)
			rdata_d = pin_fn_q[1];
	end

	always_ff @(posedge core_clk)
	begin
		if (srst)
			reg_rdata <= 8'h00;
		else if (reg_rd)
			reg_rdata <= rdata_d;
		else
			reg_rdata <= 8'h00;
	end

endmodule : lclr_regs

//--- sim/lclr_regs_asserts.sv
// checker: port-level assertions for the loop level register bank
`timescale 1ns/1ps
module lclr_chk
	import lclr_pkg::*;
(
	// watched ports
	input wire logic        core_clk,
	input wire logic        srst,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic [7:0]  loop_level_select,
	input wire logic [3:0]  loop_override_enable,
	input wire logic        level_locked,
	input wire logic [1:0]  mfp_out,
	input wire logic [1:0]  mfp_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	wire p0 = reg_wr && reg_addr == LCLR_PIN0_ADDR;
	wire p1 = reg_wr && reg_addr == LCLR_PIN1_ADDR;
	wire xa = reg_addr == LCLR_XFER_ADDR;
	wire go = reg_wr && xa && reg_wdata == LCLR_XFER_GO;
	wire la = (reg_addr & 16'hFCFF) == 16'h1488;
	a_pin_low: assert property (p0 && reg_wdata == LCLR_PIN_LOW |->
		##2 mfp_oe[0] && !mfp_out[0]) else $error("pin0 not low");
	a_pin_high: assert property (p1 && reg_wdata == LCLR_PIN_HIGH |->
		##2 mfp_oe[1] && mfp_out[1]) else $error("pin1 not high");
	a_pin_cause: assert property (!$stable({mfp_out, mfp_oe}) |->
		$past(p0 || p1, 2)) else $error("pin moved unasked");
	// levels may only move two edges after a transfer strobe
	a_xfer_only: assert property (
		!$stable({loop_level_select, loop_override_enable}) |-> $past(go, 2))
		else $error("level moved unasked");
	a_rsv_zero: assert property (reg_rd && la |=> reg_rdata[7:3] == 5'h00)
		else $error("reserved bits set");
	a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("stray read data");
	a_rst_level: assert property ($fell(srst) |-> loop_level_select == 8'h00
		&& loop_override_enable == 4'h0) else $error("level not reset");
	a_rst_lock: assert property ($fell(srst) |-> level_locked)
		else $error("key open after reset");
	c_pin: cover property (p0 && reg_wdata == LCLR_PIN_LOW);
	c_go: cover property (go);
	c_rd: cover property (reg_rd && la);
endmodule : lclr_chk

bind lclr_regs lclr_chk i_lclr_chk (.*);

//--- sim/tb.sv
// testbench: random register traffic checked against a behavioural model
`timescale 1ns/1ps
module tb
	import lclr_pkg::*;
;
	logic        core_clk = '0, srst = '1, reg_wr = '0, reg_rd = '0;
	logic [15:0] reg_addr = '0;
	logic [7:0]  reg_wdata = '0, key, reg_rdata, loop_level_select, c [4];
	logic [3:0]  loop_override_enable;
	logic [1:0]  mfp_out, mfp_oe;
	logic        level_locked;
	logic [2:0]  stg [4], act [4];
	logic [7:0]  pin [2];
	int          n_mismatch = 0, comparisons = 0, cyc = 0, i, r;
	lclr_regs i_lclr_regs (.*);
	initial forever #12.5 core_clk = ~core_clk;
	always @(posedge core_clk)
		if (++cyc == 3000)
		begin
			n_mismatch++;
			give_verdict;
		end
	task give_verdict;
		if (n_mismatch == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	task cmp(input logic [7:0] g, e);
		comparisons++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error %0t: got %h want %h", $time, g, e);
		end
	endtask : cmp
	function automatic bit lp(input logic [15:0] a);
		return (a & 16'hFCFF) == 16'h1488;
	endfunction : lp
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= '1;
		reg_rd <= '0;
		// a locked key drops the write silently
		if (lp(a) && key == LCLR_KEY_UNLOCK) stg[a[9:8]] = d[2:0];
		if (a == LCLR_KEY_ADDR) key = d;
		if (a == LCLR_XFER_ADDR && d == LCLR_XFER_GO) act = stg;
		if (a[15:1] == 15'h0100) pin[a[0]] = d;
	endtask : wr
	task rd(input logic [15:0] a);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= '1;
		reg_wr <= '0;
		@(posedge core_clk);
		reg_rd <= '0;
		#1;
		cmp(reg_rdata, lp(a) ? {5'h00, stg[a[9:8]]} :
			a[15:1] == 15'h0100 ? pin[a[0]] : 8'h00);
	endtask : rd
	task chk;
		@(posedge core_clk);
		reg_wr <= '0;
		reg_rd <= '0;
		repeat (3) @(posedge core_clk);
		#1;
		for (int k = 0; k < 4; k++)
		begin
			cmp(8'(loop_level_select[2*k+:2]), 8'(act[k][2:1]));
			cmp(8'(loop_override_enable[k]), 8'(act[k][0]));
		end
		for (int k = 0; k < 2; k++)
			cmp(8'({mfp_out[k], mfp_oe[k]}),
				8'({pin[k] == LCLR_PIN_HIGH, pin[k][7]}));
		cmp(8'(level_locked), 8'(key != LCLR_KEY_UNLOCK));
	endtask : chk
	initial
	begin
		c = '{8'h80, 8'h81, 8'h8F, 8'h00};
		void'($urandom(32'h0dae));
		// second round starts from a fresh reset, as after a power cycle
		for (r = 0; r < 2; r++)
		begin
			stg = '{default: '0};
			act = '{default: '0};
			pin = '{default: '0};
			key = '0;
			@(posedge core_clk);
			srst <= '1;
			repeat (4) @(posedge core_clk);
			srst <= '0;
			chk;
			rd(16'h1489);
			wr(LCLR_LOOP2_ADDR, 8'hFF);
			wr(LCLR_KEY_ADDR, LCLR_KEY_UNLOCK);
			for (i = 0; i < 4; i++)
				wr(16'h1488 + 16'(i << 8), r ? 8'({5'($urandom), 3'b011})
					: 8'($urandom));
			for (i = 0; i < 5; i++)
				rd(16'h1488 + 16'(i << 8));
			wr(LCLR_XFER_ADDR, 8'h02);
			chk;
			wr(LCLR_XFER_ADDR, LCLR_XFER_GO);
			chk;
			rd(LCLR_XFER_ADDR);
			for (i = 0; i < 4; i++)
			begin
				wr(LCLR_PIN0_ADDR, c[i]);
				wr(LCLR_PIN1_ADDR, c[3 - i]);
				chk;
			end
		end
		give_verdict;
	end
endmodule : tb
